/* File: design/ctf_lin11_cmp.sv */
// ctf_lin11_cmp: signed greater-than between two exponent/mantissa words
// assumes: both words use a 5-bit signed exponent and an 11-bit signed mantissa
module ctf_lin11_cmp
    import ctf_pkg::*;
(
    // operands
    input wire logic [15:0] opA,
    input wire logic [15:0] opB,
    // result
    output logic aGreater
);
    // each value becomes mantissa << (exponent + 16): a 42-bit exact fixed point
    logic [4:0] shA;
    logic [4:0] shB;
    logic signed [41:0] extA;
    logic signed [41:0] extB;
    logic signed [41:0] valA;
    logic signed [41:0] valB;

    // adding 16 to a 5-bit signed exponent is just flipping its sign bit
    assign shA = {~opA[CTF_EXP_MSB], opA[CTF_EXP_MSB-1:CTF_EXP_LSB]};
    assign shB = {~opB[CTF_EXP_MSB], opB[CTF_EXP_MSB-1:CTF_EXP_LSB]};
    assign extA = {{31{opA[CTF_MAN_MSB]}}, opA[CTF_MAN_MSB:CTF_MAN_LSB]};
    assign extB = {{31{opB[CTF_MAN_MSB]}}, opB[CTF_MAN_MSB:CTF_MAN_LSB]};
    assign valA = extA <<< shA;
    assign valB = extB <<< shB;
    assign aGreater = valA > valB;
endmodule : ctf_lin11_cmp

/* File: design/ctf_monitor.sv */
// ctf_monitor: peak/valley current and over-temperature fault-limit monitor
// assumes: samples and readings arrive as exponent/mantissa words, synchronous to clk;
// the management-bus front end presents decoded command writes and reads here
module ctf_monitor
    import ctf_pkg::*;
#(
    parameter int CNT_W = CTF_CNT_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // limit command port
    input wire logic cmdWrite,
    input wire logic cmdRead,
    input wire logic [7:0] cmdCode,
    input wire logic [15:0] cmdWrData,
    input wire logic writeProtect,
    input wire logic clearFaults,
    output logic [15:0] cmdRdData_r,
    output logic cmdRdValid_r,
    output logic cmdWrRejected_r,
    // per-phase current samples, one per switching period
    input wire logic [CTF_PHASES-1:0] sampleStrobe,
    input wire logic [CTF_PHASES-1:0] sampleInBlanking,
    input wire logic [CTF_PHASES*16-1:0] phaseCurrent,
    input wire logic [CNT_W-1:0] currentSenseSetup,
    // average-current faults from the averaging path
    input wire logic averageOvercurrentFault,
    input wire logic averageUndercurrentFault,
    // temperature readings: internal, first external, second external
    input wire logic [CTF_SENSORS-1:0] tempStrobe,
    input wire logic [CTF_SENSORS*16-1:0] tempReading,
    input wire logic [1:0] externalSensorSelect,
    // status and alert
    output logic ocFault_r,
    output logic ucFault_r,
    output logic tempSummary_r,
    output logic overheatStatusBit_r,
    output logic internalSensorFlag_r,
    output logic firstExternalSensorFlag_r,
    output logic secondExternalSensorFlag_r,
    output logic alertN_r
);
    logic [15:0] peakOcLimit_r;
    logic [15:0] valleyUcLimit_r;
    logic [15:0] otLimit_r;

    // command decode
    logic hitOc;
    logic hitUc;
    logic hitOt;
    logic hitAny;
    logic wrAllowed;
    logic [15:0] rdMux;
    assign hitOc = cmdCode == CTF_CMD_PEAK_OC;
    assign hitUc = cmdCode == CTF_CMD_VALLEY_UC;
    assign hitOt = cmdCode == CTF_CMD_OT_LIMIT;
    assign hitAny = hitOc | hitUc | hitOt;
    assign wrAllowed = cmdWrite & hitAny & ~writeProtect;
    assign rdMux = hitOc ? peakOcLimit_r : hitUc ? valleyUcLimit_r : hitOt ? otLimit_r : 16'h0000;

    // limit write path: a protected write leaves every limit untouched
    logic [15:0] peakOcLimit_nxt;
    logic [15:0] valleyUcLimit_nxt;
    logic [15:0] otLimit_nxt;
    assign peakOcLimit_nxt = (wrAllowed & hitOc) ? cmdWrData : peakOcLimit_r;
    assign valleyUcLimit_nxt = (wrAllowed & hitUc) ? cmdWrData : valleyUcLimit_r;
    assign otLimit_nxt = (wrAllowed & hitOt) ? cmdWrData : otLimit_r;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            peakOcLimit_r <= CTF_RST_PEAK_OC;
        end else begin
            peakOcLimit_r <= peakOcLimit_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            valleyUcLimit_r <= CTF_RST_VALLEY_UC;
        end else begin
            valleyUcLimit_r <= valleyUcLimit_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            otLimit_r <= CTF_RST_OT_LIMIT;
        end else begin
            otLimit_r <= otLimit_nxt;
        end
    end

    // read answers one cycle after the request; unknown codes read zero
    logic [15:0] cmdRdData_nxt;
    logic cmdRdValid_nxt;
    logic cmdWrRejected_nxt;
    assign cmdRdData_nxt = cmdRead ? rdMux : cmdRdData_r;
    assign cmdRdValid_nxt = cmdRead;
    assign cmdWrRejected_nxt = cmdWrite & hitAny & writeProtect;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cmdRdData_r <= 16'h0000;
        end else begin
            cmdRdData_r <= cmdRdData_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cmdRdValid_r <= 1'b0;
        end else begin
            cmdRdValid_r <= cmdRdValid_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cmdWrRejected_r <= 1'b0;
        end else begin
            cmdWrRejected_r <= cmdWrRejected_nxt;
        end
    end

    // fault threshold in periods; a setting of zero acts as one
    logic [CNT_W-1:0] needCount;
    assign needCount = (currentSenseSetup == '0) ? CNT_W'(1) : currentSenseSetup;

    logic [CTF_PHASES-1:0] ocTrip;
    logic [CTF_PHASES-1:0] ucTrip;

    genvar gp;
    generate
        for (gp = 0; gp < CTF_PHASES; gp++) begin : gPhase
            logic [15:0] sample;
            logic above;
            logic below;
            logic take;
            logic [CNT_W-1:0] ocCnt_r;
            logic [CNT_W-1:0] ucCnt_r;
            logic [CNT_W-1:0] ocCnt_nxt;
            logic [CNT_W-1:0] ucCnt_nxt;
            assign sample = phaseCurrent[gp*16 +: 16];
            ctf_lin11_cmp uCmpOc (
                .opA(sample),
                .opB(peakOcLimit_r),
                .aGreater(above)
            );
            ctf_lin11_cmp uCmpUc (
                .opA(valleyUcLimit_r),
                .opB(sample),
                .aGreater(below)
            );
            assign take = sampleStrobe[gp] & ~sampleInBlanking[gp];
            // saturating counters of consecutive violating periods
            assign ocCnt_nxt = !above ? '0 : (ocCnt_r == needCount) ? ocCnt_r : ocCnt_r + CNT_W'(1);
            assign ucCnt_nxt = !below ? '0 : (ucCnt_r == needCount) ? ucCnt_r : ucCnt_r + CNT_W'(1);
            assign ocTrip[gp] = take & above & (ocCnt_nxt == needCount);
            assign ucTrip[gp] = take & below & (ucCnt_nxt == needCount);
            // blanked or absent samples leave the counters alone
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    ocCnt_r <= '0;
                end else if (take) begin
                    ocCnt_r <= ocCnt_nxt;
                end
            end
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    ucCnt_r <= '0;
                end else if (take) begin
                    ucCnt_r <= ucCnt_nxt;
                end
            end
        end
    endgenerate

    // temperature: sensor 0 always watched, externals per select bits
    logic [CTF_SENSORS-1:0] sensorOn;
    logic [CTF_SENSORS-1:0] otTrip;
    assign sensorOn = {externalSensorSelect[1], externalSensorSelect[0], 1'b1};

    genvar gs;
    generate
        for (gs = 0; gs < CTF_SENSORS; gs++) begin : gSensor
            logic hot;
            ctf_lin11_cmp uCmpOt (
                .opA(tempReading[gs*16 +: 16]),
                .opB(otLimit_r),
                .aGreater(hot)
            );
            assign otTrip[gs] = tempStrobe[gs] & sensorOn[gs] & hot;
        end
    endgenerate

    // sticky status: a new event in the clearing cycle wins over the clear
    logic ocSet;
    logic ucSet;
    logic otSet;
    logic faultAny;
    assign ocSet = (|ocTrip) | averageOvercurrentFault;
    assign ucSet = (|ucTrip) | averageUndercurrentFault;
    assign otSet = |otTrip;
    assign faultAny = ocSet | ucSet | otSet | ((ocFault_r | ucFault_r | tempSummary_r) & ~clearFaults);

    logic ocFault_nxt;
    logic ucFault_nxt;
    logic tempSummary_nxt;
    logic overheatStatusBit_nxt;
    logic internalSensorFlag_nxt;
    logic firstExternalSensorFlag_nxt;
    logic secondExternalSensorFlag_nxt;
    logic alertN_nxt;
    assign ocFault_nxt = ocSet | (ocFault_r & ~clearFaults);
    assign ucFault_nxt = ucSet | (ucFault_r & ~clearFaults);
    assign tempSummary_nxt = otSet | (tempSummary_r & ~clearFaults);
    assign overheatStatusBit_nxt = otSet | (overheatStatusBit_r & ~clearFaults);
    assign internalSensorFlag_nxt = otTrip[0] | (internalSensorFlag_r & ~clearFaults);
    assign firstExternalSensorFlag_nxt = otTrip[1] | (firstExternalSensorFlag_r & ~clearFaults);
    assign secondExternalSensorFlag_nxt = otTrip[2] | (secondExternalSensorFlag_r & ~clearFaults);
    assign alertN_nxt = ~faultAny;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ocFault_r <= 1'b0;
        end else begin
            ocFault_r <= ocFault_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ucFault_r <= 1'b0;
        end else begin
            ucFault_r <= ucFault_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            tempSummary_r <= 1'b0;
        end else begin
            tempSummary_r <= tempSummary_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            overheatStatusBit_r <= 1'b0;
        end else begin
            overheatStatusBit_r <= overheatStatusBit_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            internalSensorFlag_r <= 1'b0;
        end else begin
            internalSensorFlag_r <= internalSensorFlag_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            firstExternalSensorFlag_r <= 1'b0;
        end else begin
            firstExternalSensorFlag_r <= firstExternalSensorFlag_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            secondExternalSensorFlag_r <= 1'b0;
        end else begin
            secondExternalSensorFlag_r <= secondExternalSensorFlag_nxt;
        end
    end

    // alert idles high and drops in the same cycle as the status bit
    always_ff @(posedge clk) begin
        if (!nrst) begin
            alertN_r <= 1'b1;
        end else begin
            alertN_r <= alertN_nxt;
        end
    end
endmodule : ctf_monitor

/* File: design/ctf_pkg.sv */
// ctf_pkg: constants of the current and temperature fault-limit monitor
// assumes: 16-bit limits in two's-complement exponent/mantissa form
package ctf_pkg;
    // command codes of the limit registers
    localparam logic [7:0] CTF_CMD_PEAK_OC = 8'h46;
    localparam logic [7:0] CTF_CMD_VALLEY_UC = 8'h4B;
    localparam logic [7:0] CTF_CMD_OT_LIMIT = 8'h4F;
    // values after reset: 30 A, -15 A, +125 C
    localparam logic [15:0] CTF_RST_PEAK_OC = 16'hDBC0;
    localparam logic [15:0] CTF_RST_VALLEY_UC = 16'hD440;
    localparam logic [15:0] CTF_RST_OT_LIMIT = 16'hEBE8;
    // field positions inside a limit word
    localparam int CTF_EXP_MSB = 15;
    localparam int CTF_EXP_LSB = 11;
    localparam int CTF_MAN_MSB = 10;
    localparam int CTF_MAN_LSB = 0;
    // width of the consecutive-period count setting
    localparam int CTF_CNT_W = 3;
    // number of phases and temperature sensors
    localparam int CTF_PHASES = 2;
    localparam int CTF_SENSORS = 3;
endpackage : ctf_pkg

/* File: dv/ctf_host_model.sv */
// ctf_host_model: management host that writes limits and reads them back
// assumes: monitor samples on rising clk; this model moves only at falling clk
module ctf_host_model
    import ctf_pkg::*;
(
    // clock
    input wire logic clk,
    // command toward the monitor
    output logic cmdWrite,
    output logic cmdRead,
    output logic [7:0] cmdCode,
    output logic [15:0] cmdWrData,
    // read answer
    input wire logic [15:0] cmdRdData,
    input wire logic cmdRdValid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmdWrite = 1'b0;
        cmdRead = 1'b0;
        cmdCode = 8'h00;
        cmdWrData = 16'h0000;
    end
    // exponent in 15:11, mantissa in 10:0, value is mantissa times two^exponent
    function automatic logic [15:0] lin11(input logic signed [4:0] e, input logic signed [10:0] m);
        return {e, m};
    endfunction : lin11
    // released lines show the inverse so stale values cannot pass
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(negedge clk);
        cmdCode = c;
        cmdWrData = d;
        cmdWrite = 1'b1;
        @(negedge clk);
        cmdWrite = 1'b0;
        cmdWrData = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] c, output logic [15:0] d);
        @(negedge clk);
        cmdCode = c;
        cmdRead = 1'b1;
        @(negedge clk);
        cmdRead = 1'b0;
        cmdCode = ~c;
        d = cmdRdValid ? cmdRdData : 16'hxxxx;
    endtask : rd
endmodule : ctf_host_model

/* File: dv/ctf_monitor_props.sv */
// ctf_monitor_props: port-level checks of the fault-limit monitor
// assumes: bound onto ctf_monitor, single clock domain, nrst synchronous
module ctf_monitor_props
    import ctf_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // command port
    input wire logic cmdWrite,
    input wire logic cmdRead,
    input wire logic [7:0] cmdCode,
    input wire logic [15:0] cmdWrData,
    input wire logic writeProtect,
    input wire logic clearFaults,
    input wire logic [15:0] cmdRdData_r,
    input wire logic cmdRdValid_r,
    input wire logic cmdWrRejected_r,
    // event sources
    input wire logic [CTF_PHASES-1:0] sampleStrobe,
    input wire logic [CTF_SENSORS-1:0] tempStrobe,
    input wire logic averageOvercurrentFault,
    input wire logic averageUndercurrentFault,
    // status
    input wire logic ocFault_r,
    input wire logic ucFault_r,
    input wire logic tempSummary_r,
    input wire logic overheatStatusBit_r,
    input wire logic firstExternalSensorFlag_r,
    input wire logic alertN_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // unprotected write, quiet cycle, then a read of the same limit
    sequence ot_wr_rd_s;
        (cmdWrite && !writeProtect && cmdCode == CTF_CMD_OT_LIMIT) ##1 !cmdWrite
            ##1 (cmdRead && !cmdWrite && cmdCode == CTF_CMD_OT_LIMIT);
    endsequence
    AST_WR_RD: assert property (ot_wr_rd_s |=> cmdRdData_r == $past(cmdWrData, 3))
        else $error("limit read back differs from write");
    AST_RD_VALID: assert property (cmdRead |=> cmdRdValid_r ##1 (cmdRdValid_r == $past(cmdRead)))
        else $error("read answer timing wrong");
    AST_WR_REJECT: assert property (cmdWrite && writeProtect && cmdCode == CTF_CMD_PEAK_OC |=> cmdWrRejected_r)
        else $error("protected write not refused");
    AST_OC_STICKY: assert property (ocFault_r && !clearFaults |=> ocFault_r)
        else $error("overcurrent bit dropped without clear");
    AST_OC_CLEAR: assert property (clearFaults && !averageOvercurrentFault && sampleStrobe == '0 |=> !ocFault_r)
        else $error("overcurrent bit survived clear");
    AST_ALERT: assert property (ocFault_r || ucFault_r || tempSummary_r |-> !alertN_r)
        else $error("alert not low with fault set");
    AST_AVG_OC: assert property (averageOvercurrentFault |=> ocFault_r)
        else $error("average overcurrent not on shared bit");
    AST_AVG_UC: assert property (averageUndercurrentFault |=> ucFault_r)
        else $error("average undercurrent not on shared bit");
    AST_OT_FLAGS: assert property ($rose(firstExternalSensorFlag_r) |-> tempSummary_r && overheatStatusBit_r)
        else $error("sensor flag without summary bits");
    AST_OT_CLEAR: assert property (clearFaults && tempStrobe == '0 |=> !tempSummary_r)
        else $error("temperature summary survived clear");
endmodule : ctf_monitor_props

bind ctf_monitor ctf_monitor_props ctf_monitor_props_i (.clk(clk), .nrst(nrst), .cmdWrite(cmdWrite),
    .cmdRead(cmdRead), .cmdCode(cmdCode), .cmdWrData(cmdWrData), .writeProtect(writeProtect),
    .clearFaults(clearFaults), .cmdRdData_r(cmdRdData_r), .cmdRdValid_r(cmdRdValid_r),
    .cmdWrRejected_r(cmdWrRejected_r), .sampleStrobe(sampleStrobe), .tempStrobe(tempStrobe),
    .averageOvercurrentFault(averageOvercurrentFault), .averageUndercurrentFault(averageUndercurrentFault),
    .ocFault_r(ocFault_r), .ucFault_r(ucFault_r), .tempSummary_r(tempSummary_r),
    .overheatStatusBit_r(overheatStatusBit_r), .firstExternalSensorFlag_r(firstExternalSensorFlag_r),
    .alertN_r(alertN_r));

/* File: dv/ctf_monitor_tb.sv */
// ctf_monitor_tb: self-checking bench of the fault-limit monitor
// assumes: host model drives the command port; bench drives samples at falling clk
module ctf_monitor_tb
    import ctf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, nrst, cmdWrite, cmdRead, writeProtect, clearFaults, cmdRdValid_r, cmdWrRejected_r;
    logic [7:0] cmdCode;
    logic [15:0] cmdWrData, cmdRdData_r, v;
    logic [1:0] sampleStrobe, sampleInBlanking, externalSensorSelect, avgFault;
    logic [31:0] phaseCurrent;
    logic [2:0] currentSenseSetup, tempStrobe;
    logic [47:0] tempReading;
    logic [7:0] st;
    int n_mismatch = 0;
    int cmp_count = 0;
    ctf_host_model ctf_host_model_i (.clk(clk), .cmdWrite(cmdWrite), .cmdRead(cmdRead), .cmdCode(cmdCode),
        .cmdWrData(cmdWrData), .cmdRdData(cmdRdData_r), .cmdRdValid(cmdRdValid_r));
    ctf_monitor ctf_monitor_i (.clk(clk), .nrst(nrst), .cmdWrite(cmdWrite), .cmdRead(cmdRead), .cmdCode(cmdCode),
        .cmdWrData(cmdWrData), .writeProtect(writeProtect), .clearFaults(clearFaults), .cmdRdData_r(cmdRdData_r),
        .cmdRdValid_r(cmdRdValid_r), .cmdWrRejected_r(cmdWrRejected_r), .sampleStrobe(sampleStrobe),
        .sampleInBlanking(sampleInBlanking), .phaseCurrent(phaseCurrent), .currentSenseSetup(currentSenseSetup),
        .averageOvercurrentFault(avgFault[1]), .averageUndercurrentFault(avgFault[0]), .tempStrobe(tempStrobe),
        .tempReading(tempReading), .externalSensorSelect(externalSensorSelect), .ocFault_r(st[7]), .ucFault_r(st[6]),
        .tempSummary_r(st[5]), .overheatStatusBit_r(st[4]), .internalSensorFlag_r(st[3]),
        .firstExternalSensorFlag_r(st[2]), .secondExternalSensorFlag_r(st[1]), .alertN_r(st[0]));
    always #2 clk = ~clk;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic smp(input int p, input logic [15:0] val, input logic blank);
        @(negedge clk);
        sampleStrobe[p] = 1'b1;
        sampleInBlanking[p] = blank;
        phaseCurrent[16*p +: 16] = val;
        @(negedge clk);
        sampleStrobe = 2'b00;
    endtask : smp
    task automatic tmp(input int i);
        @(negedge clk);
        tempStrobe[i] = 1'b1;
        tempReading[16*i +: 16] = 16'hEBF0;
        @(negedge clk);
        tempStrobe = 3'b000;
    endtask : tmp
    task automatic clr();
        @(negedge clk);
        clearFaults = 1'b1;
        @(negedge clk);
        clearFaults = 1'b0;
        check({8'h00, st}, 16'h0001);
    endtask : clr
    task automatic t_regs();
        ctf_host_model_i.rd(CTF_CMD_PEAK_OC, v);
        check(v, 16'hDBC0);
        ctf_host_model_i.rd(CTF_CMD_VALLEY_UC, v);
        check(v, 16'hD440);
        ctf_host_model_i.rd(CTF_CMD_OT_LIMIT, v);
        check(v, 16'hEBE8);
        writeProtect = 1'b1;
        ctf_host_model_i.wr(CTF_CMD_PEAK_OC, 16'h1234);
        check({15'h0000, cmdWrRejected_r}, 16'h0001);
        writeProtect = 1'b0;
        ctf_host_model_i.rd(CTF_CMD_PEAK_OC, v);
        check(v, 16'hDBC0);
        ctf_host_model_i.wr(CTF_CMD_OT_LIMIT, 16'h1A2B);
        ctf_host_model_i.rd(CTF_CMD_OT_LIMIT, v);
        check(v, 16'h1A2B);
        ctf_host_model_i.wr(CTF_CMD_OT_LIMIT, 16'hEBE8);
        ctf_host_model_i.rd(8'h47, v);
        check(v, 16'h0000);
    endtask : t_regs
    task automatic t_current();
        smp(1, 16'hDBC1, 1'b1);
        smp(1, 16'hDBC1, 1'b1);
        check({8'h00, st}, 16'h0001);
        smp(0, 16'hDBC1, 1'b0);
        smp(0, ctf_host_model_i.lin11(-4, 480), 1'b0);
        smp(0, 16'hDBC1, 1'b0);
        check({8'h00, st}, 16'h0001);
        smp(0, ctf_host_model_i.lin11(-4, 496), 1'b0);
        check({8'h00, st}, 16'h0080);
        clr();
        smp(1, ctf_host_model_i.lin11(-6, -1024), 1'b0);
        smp(1, ctf_host_model_i.lin11(-6, -1024), 1'b0);
        check({8'h00, st}, 16'h0040);
        clr();
        for (int i = 0; i < 2; i++) begin
            @(negedge clk);
            avgFault = 2'b10 >> i;
            @(negedge clk);
            avgFault = 2'b00;
            check({8'h00, st}, 16'h0080 >> i);
            clr();
        end
    endtask : t_current
    task automatic t_temp();
        tmp(2);
        check({8'h00, st}, 16'h0001);
        externalSensorSelect = 2'b11;
        for (int i = 0; i < 3; i++) begin
            tmp(i);
            check({8'h00, st}, 16'h0030 | (16'h0008 >> i));
            clr();
        end
    endtask : t_temp
    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    initial begin
        {clk, nrst, writeProtect, clearFaults, sampleStrobe, sampleInBlanking, avgFault, tempStrobe} = '0;
        {phaseCurrent, tempReading} = '0;
        currentSenseSetup = 3'd2;
        externalSensorSelect = 2'b01;
        repeat (3) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        t_regs();
        t_current();
        t_temp();
        report_and_stop();
    end
    initial begin
        #20000;
        n_mismatch++;
        report_and_stop();
    end
endmodule : ctf_monitor_tb
